/* File: logic/sledi_pkg.sv */
// Purpose: shared constants for the status indicator block
// Assumes: 100 MHz system clock
// Notes:   blink periods are derived from the clock rate
package sledi_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SLOW_HZ       = 1;     // slow blink, cycles per second
  localparam int unsigned FAST_HZ       = 16;    // fast blink, cycles per second
  localparam int unsigned STARTUP_HZ    = 8;     // startup blinks within one second
  localparam int unsigned STARTUP_BLINKS = 8;
  localparam int unsigned PULSE_US      = 20000; // suspend pulse width
  localparam int unsigned FLICK_US      = 20000; // activity off time
  localparam int unsigned US_CYC        = CLK_HZ / 1_000_000;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam int unsigned PULSE_CYC     = PULSE_US * US_CYC;
  localparam int unsigned FLICK_CYC     = FLICK_US * US_CYC;

  // ---------------------------------------------------------------
  // feedback modes and reach tolerance
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SLEDI_FB_NONE,
    SLEDI_FB_ANALOG,
    SLEDI_FB_FREQ
  } sledi_fb_mode_t;

  localparam int unsigned VAL_W    = 16;
  localparam int unsigned DUTY_W   = 11;
  localparam logic [15:0] REACH_TOL = 16'h0014;  // 20 counts

  // ---------------------------------------------------------------
  // register offsets and interrupt bits
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_IRQ_ST = 4'h4;
  localparam logic [3:0]  REG_IRQ_MK = 4'h8;
  localparam int unsigned IRQ_W      = 4;
  localparam int unsigned IRQ_ERR    = 0;  // stopping error appeared
  localparam int unsigned IRQ_CLR    = 1;  // stopping error cleared
  localparam int unsigned IRQ_REACH  = 2;  // desired state reached
  localparam int unsigned IRQ_RECOG  = 3;  // host recognition received
  localparam logic [3:0]  IRQ_MK_RST = 4'h0;

endpackage : sledi_pkg

/* File: logic/sledi_tick.sv */
// Purpose: free-running tick counter producing square-wave phases
// Assumes: single clock, asynchronous active-low reset
// Notes:   phases are counted from reset or the last i_restart; unrestarted instances share one time base
`timescale 1ns/1ps
module sledi_tick #(
  parameter int unsigned PERIOD = 100
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_restart,
  output logic      o_wrap,
  output logic      o_high
);

  localparam int unsigned CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  localparam logic [CW-1:0] HALF = CW'(PERIOD / 2);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (i_restart || cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign o_wrap = (cnt_r == LAST);
  assign o_high = (cnt_r < HALF);

endmodule : sledi_tick

/* File: logic/sledi_top.sv */
// Purpose: drives green, yellow, red indicators and the error line
// Assumes: all status inputs synchronous to i_clock
// Notes:   register port gives status, sticky events and a mask
`timescale 1ns/1ps

// Functional notes
// - USB connected, not yet recognised: green blinks slowly.
// - After recognition green stays on, flickers off on USB traffic.
// - Suspended on USB power: green gives one short pulse per second.
// - Red lit exactly when a stopping error other than awaiting-command exists or startup is in progress.
// - Red indicator and error pin come from the same signal.
// - Error pin low without stopping error or startup, driven high with either.
// - Stopping error keeps yellow off.
// - Awaiting command or zero open-loop duty: yellow blinks at 1 Hz.
// - Running and reached: yellow solid on.
// - Analog or frequency feedback: reached when |target - feedback| <= 20.
// - Open-loop: reached when duty equals duty target.
// - Running, not reached: yellow flashes at 16 Hz.
// - After special reset: red on, eight yellow blinks in a second, motor held.
module sledi_top #(
  parameter int unsigned CLK_HZ     = sledi_pkg::CLK_HZ,
  parameter int unsigned SEC_CYC    = sledi_pkg::SEC_CYC,
  parameter int unsigned PULSE_CYC  = sledi_pkg::PULSE_CYC,
  parameter int unsigned FLICK_CYC  = sledi_pkg::FLICK_CYC
) (
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_usb_connected,
  input  wire logic                          i_usb_recognized,
  input  wire logic                          i_usb_activity,
  input  wire logic                          i_usb_suspended,
  input  wire logic                          i_stop_error,
  input  wire logic                          i_awaiting_cmd,
  input  wire logic                          i_motor_on,
  input  wire logic [1:0]                    i_fb_mode,
  input  wire logic [sledi_pkg::VAL_W-1:0]   i_target,
  input  wire logic [sledi_pkg::VAL_W-1:0]   i_scaled_fb,
  input  wire logic [sledi_pkg::DUTY_W-1:0]  i_duty,
  input  wire logic [sledi_pkg::DUTY_W-1:0]  i_duty_target,
  input  wire logic                          i_special_reset,
  input  wire logic [sledi_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sledi_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic [sledi_pkg::DATA_W-1:0]       o_rdata,
  output logic                               o_led_green,
  output logic                               o_led_yellow,
  output logic                               o_led_red,
  output logic                               o_err,
  output logic                               o_startup_hold,
  output logic                               o_irq
);

  // ---------------------------------------------------------------
  // derived periods
  // ---------------------------------------------------------------
  // SEC_CYC must divide by 16 and 8, else blink rates drift
  localparam int unsigned FAST_CYC  = SEC_CYC / sledi_pkg::FAST_HZ;
  localparam int unsigned SLOW_CYC  = SEC_CYC / sledi_pkg::SLOW_HZ;
  localparam int unsigned START_CYC = SEC_CYC / sledi_pkg::STARTUP_HZ;
  localparam int unsigned FW        = $clog2(FLICK_CYC + 1);
  localparam int unsigned PW        = $clog2(SEC_CYC + 1);
  localparam logic [FW-1:0] FLICK_LD = FW'(FLICK_CYC);
  localparam logic [PW-1:0] PULSE_LIM = PW'(PULSE_CYC);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [sledi_pkg::VAL_W-1:0] abs_diff(
    input logic [sledi_pkg::VAL_W-1:0] a,
    input logic [sledi_pkg::VAL_W-1:0] b
  );
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction : abs_diff

  // ---------------------------------------------------------------
  // startup blink sequence
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SLEDI_ST_CAPTURE,
    SLEDI_ST_BLINK,
    SLEDI_ST_RUN
  } sledi_st_t;

  sledi_st_t  st_r;
  logic [3:0] blinks_r;
  logic       start_wrap;
  logic       start_high;

  // reset cause is only valid after release, so it is sampled then
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r     <= SLEDI_ST_CAPTURE;
      blinks_r <= 4'h0;
    end else begin
      case (st_r)
        SLEDI_ST_CAPTURE: begin
          blinks_r <= 4'h0;
          st_r     <= i_special_reset ? SLEDI_ST_BLINK : SLEDI_ST_RUN;
        end
        SLEDI_ST_BLINK: begin
          if (start_wrap) begin
            blinks_r <= blinks_r + 4'h1;
            if (blinks_r == 4'(sledi_pkg::STARTUP_BLINKS - 1)) begin
              st_r <= SLEDI_ST_RUN;
            end
          end
        end
        default: begin
          st_r <= SLEDI_ST_RUN;
        end
      endcase
    end
  end

  // motor, commands and inputs stay held until the blinks are done
  logic startup;
  assign startup = (st_r != SLEDI_ST_RUN);

  // ---------------------------------------------------------------
  // tick counters
  // ---------------------------------------------------------------
  logic slow_high;
  logic fast_high;
  logic sec_wrap;

  // never restarted, so slow and fast blinks share one phase
  sledi_tick #(.PERIOD(SLOW_CYC)) u_slow (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_restart (1'b0),
    .o_wrap    (sec_wrap),
    .o_high    (slow_high)
  );

  sledi_tick #(.PERIOD(FAST_CYC)) u_fast (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_restart (1'b0),
    .o_wrap    (),
    .o_high    (fast_high)
  );

  sledi_tick #(.PERIOD(START_CYC)) u_start (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_restart (st_r == SLEDI_ST_CAPTURE),
    .o_wrap    (start_wrap),
    .o_high    (start_high)
  );

  // ---------------------------------------------------------------
  // suspend pulse and activity flicker
  // ---------------------------------------------------------------
  logic [PW-1:0] pulse_cnt_r;
  logic [FW-1:0] flick_r;

  // pulse window is the start of each second of the slow counter
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_cnt_r <= '0;
    end else if (sec_wrap) begin
      pulse_cnt_r <= '0;
    end else if (pulse_cnt_r != PULSE_LIM) begin
      pulse_cnt_r <= pulse_cnt_r + PW'(1);
    end
  end

  // each new activity beat restarts the off time
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flick_r <= '0;
    end else if (i_usb_activity) begin
      flick_r <= FLICK_LD;
    end else if (flick_r != '0) begin
      flick_r <= flick_r - FW'(1);
    end
  end

  // ---------------------------------------------------------------
  // indicator decisions
  // ---------------------------------------------------------------
  logic green_nxt;
  logic yellow_nxt;
  logic red_nxt;
  logic reached;
  logic open_loop;

  always_comb begin
    open_loop = (i_fb_mode == 2'(sledi_pkg::SLEDI_FB_NONE));
    if (open_loop) begin
      reached = (i_duty == i_duty_target);
    end else begin
      // unused mode code falls back to the tolerance test
      reached = (abs_diff(i_target, i_scaled_fb) <= sledi_pkg::REACH_TOL);
    end
  end

  always_comb begin
    // host asleep: suspend outranks the connection state
    if (i_usb_suspended) begin
      green_nxt = (pulse_cnt_r != PULSE_LIM);
    end else if (!i_usb_connected) begin
      green_nxt = 1'b0;
    end else if (!i_usb_recognized) begin
      green_nxt = slow_high;
    end else begin
      green_nxt = (flick_r == '0);
    end
  end

  always_comb begin
    red_nxt = i_stop_error;
    if (startup) begin
      red_nxt    = 1'b1;
      yellow_nxt = (st_r == SLEDI_ST_BLINK) && start_high;
    end else if (i_stop_error) begin
      yellow_nxt = 1'b0;
    end else if (i_awaiting_cmd || (open_loop && i_duty == '0)) begin
      yellow_nxt = slow_high;
    end else if (i_motor_on && reached) begin
      yellow_nxt = 1'b1;
    end else if (i_motor_on) begin
      yellow_nxt = fast_high;
    end else begin
      yellow_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output flops
  // ---------------------------------------------------------------
  // red and error line share red_nxt, so they cannot disagree
  logic err_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_led_green    <= 1'b0;
      o_led_yellow   <= 1'b0;
      err_r          <= 1'b0;
      o_led_red      <= 1'b0;
      o_err          <= 1'b0;
      o_startup_hold <= 1'b1;
    end else begin
      o_led_green    <= green_nxt;
      o_led_yellow   <= yellow_nxt;
      err_r          <= i_stop_error;
      o_led_red      <= red_nxt;
      o_err          <= red_nxt;
      o_startup_hold <= startup;
    end
  end

  // ---------------------------------------------------------------
  // event status, mask and interrupt
  // ---------------------------------------------------------------
  logic [sledi_pkg::IRQ_W-1:0] irq_st_r;
  logic [sledi_pkg::IRQ_W-1:0] irq_mk_r;
  logic [sledi_pkg::IRQ_W-1:0] ev;
  logic                        reach_r;
  logic                        recog_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reach_r <= 1'b0;
      recog_r <= 1'b0;
    end else begin
      reach_r <= i_motor_on && reached;
      recog_r <= i_usb_recognized;
    end
  end

  always_comb begin
    // events are edges against last cycle's level
    ev                       = '0;
    ev[sledi_pkg::IRQ_ERR]   = i_stop_error && !err_r;
    ev[sledi_pkg::IRQ_CLR]   = !i_stop_error && err_r;
    ev[sledi_pkg::IRQ_REACH] = i_motor_on && reached && !reach_r;
    ev[sledi_pkg::IRQ_RECOG] = i_usb_recognized && !recog_r;
  end

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_st_r <= '0;
    end else if (i_wr && i_addr == sledi_pkg::REG_IRQ_ST) begin
      irq_st_r <= (irq_st_r & ~i_wdata[sledi_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_st_r <= irq_st_r | ev;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // closed at reset: no interrupt until software opts in
      irq_mk_r <= sledi_pkg::IRQ_MK_RST;
    end else if (i_wr && i_addr == sledi_pkg::REG_IRQ_MK) begin
      irq_mk_r <= i_wdata[sledi_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_st_r & irq_mk_r);
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [sledi_pkg::DATA_W-1:0] rdata_nxt;

  always_comb begin
    if (i_addr == sledi_pkg::REG_STATUS) begin
      rdata_nxt = {26'h0, o_startup_hold, reached, o_err,
                   o_led_yellow, o_led_green, o_led_red};
    end else if (i_addr == sledi_pkg::REG_IRQ_ST) begin
      rdata_nxt = {28'h0, irq_st_r};
    end else if (i_addr == sledi_pkg::REG_IRQ_MK) begin
      rdata_nxt = {28'h0, irq_mk_r};
    end else begin
      // unmapped offsets read as zero
      rdata_nxt = '0;
    end
  end

  // read data stands for exactly one cycle after the strobe
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : sledi_top

/* File: tb/sledi_led_mon.sv */
// Purpose: far side: watches the indicators, models the shared error line
// Assumes: counters restart on i_clear
// Notes:   line is pulled low, any device may drive it high
`timescale 1ns/1ps
module sledi_led_mon (
  input  wire logic i_clock,
  input  wire logic i_clear,
  input  wire logic i_green,
  input  wire logic i_yellow,
  input  wire logic i_err,
  input  wire logic i_peer_err,
  output logic      o_shared_err,
  output int        o_y_hi,
  output int        o_y_rise,
  output int        o_g_hi,
  output int        o_g_rise
);
  logic y_r;
  logic g_r;
  assign o_shared_err = i_err | i_peer_err;
  always_ff @(posedge i_clock) begin
    y_r <= i_yellow;
    g_r <= i_green;
    if (i_clear) begin
      o_y_hi   <= 0;
      o_y_rise <= 0;
      o_g_hi   <= 0;
      o_g_rise <= 0;
    end else begin
      o_y_hi   <= o_y_hi + int'(i_yellow);
      o_y_rise <= o_y_rise + int'(i_yellow && !y_r);
      o_g_hi   <= o_g_hi + int'(i_green);
      o_g_rise <= o_g_rise + int'(i_green && !g_r);
    end
  end
endmodule : sledi_led_mon

/* File: tb/sledi_properties.sv */
// Purpose: port checks for the indicator block
// Assumes: outputs lag inputs by one cycle
// Notes:   blink widths judged only while the mode is steady
`timescale 1ns/1ps
module sledi_properties #(
  parameter int unsigned SEC_CYC = 1600
) (
  input wire logic                         i_clock,
  input wire logic                         i_rst_n,
  input wire logic                         i_usb_connected,
  input wire logic                         i_usb_suspended,
  input wire logic                         i_stop_error,
  input wire logic                         i_awaiting_cmd,
  input wire logic                         i_motor_on,
  input wire logic [1:0]                   i_fb_mode,
  input wire logic [sledi_pkg::VAL_W-1:0]  i_target,
  input wire logic [sledi_pkg::VAL_W-1:0]  i_scaled_fb,
  input wire logic [sledi_pkg::DUTY_W-1:0] i_duty,
  input wire logic [sledi_pkg::DUTY_W-1:0] i_duty_target,
  input wire logic                         i_rd,
  input wire logic [sledi_pkg::DATA_W-1:0] o_rdata,
  input wire logic                         o_led_green,
  input wire logic                         o_led_yellow,
  input wire logic                         o_led_red,
  input wire logic                         o_err,
  input wire logic                         o_startup_hold
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // --------------------------------------------------------------
  // expected yellow mode, aligned with the outputs
  // --------------------------------------------------------------
  logic [15:0] dif;
  logic        reach;
  logic        norm;
  logic        yl_r;
  logic        hold_r;
  logic [1:0]  code;
  logic [1:0]  code_r;
  logic [1:0]  prev_r;
  logic [1:0]  run_r;
  logic [31:0] len_r;
  assign dif   = (i_target > i_scaled_fb) ? i_target - i_scaled_fb : i_scaled_fb - i_target;
  assign reach = (i_fb_mode == 2'h0) ? (i_duty == i_duty_target) : (dif <= sledi_pkg::REACH_TOL);
  assign norm  = !o_startup_hold && !hold_r;
  always_comb begin
    if (i_stop_error) code = 2'h0;
    else if (i_awaiting_cmd || (i_fb_mode == 2'h0 && i_duty == 11'h0)) code = 2'h1;
    else if (i_motor_on && reach) code = 2'h2;
    else if (i_motor_on) code = 2'h3;
    else code = 2'h0;
  end
  // a run only counts if it began on a phase edge, not a mode change
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_r <= 2'h0;
      prev_r <= 2'h0;
      run_r  <= 2'h0;
      yl_r   <= 1'b0;
      hold_r <= 1'b1;
      len_r  <= 32'h0;
    end else begin
      code_r <= code;
      prev_r <= code_r;
      yl_r   <= o_led_yellow;
      hold_r <= o_startup_hold;
      len_r  <= o_led_yellow ? len_r + 32'h1 : 32'h0;
      if (!norm || code_r != prev_r) run_r <= 2'h0;
      else if (o_led_yellow && !yl_r) run_r <= code_r;
    end
  end
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_err_mirror: assert property (o_err == o_led_red)
    else $error("error line differs from red");
  a_red_follows: assert property (norm |-> o_led_red == $past(i_stop_error))
    else $error("red does not follow stopping error");
  a_yellow_err_off: assert property (norm && $past(i_stop_error) |-> !o_led_yellow)
    else $error("yellow lit during stopping error");
  a_yellow_solid: assert property (norm && code_r == 2'h2 |-> o_led_yellow)
    else $error("yellow not solid when reached");
  a_blink_fast: assert property ($fell(o_led_yellow) && run_r == 2'h3 && code_r == prev_r
    |-> len_r == SEC_CYC / 32) else $error("fast blink width wrong");
  a_blink_slow: assert property ($fell(o_led_yellow) && run_r == 2'h1 && code_r == prev_r
    |-> len_r == SEC_CYC / 2) else $error("slow blink width wrong");
  a_green_idle: assert property (norm && !$past(i_usb_connected) && !$past(i_usb_suspended)
    |-> !o_led_green) else $error("green lit without host");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule : sledi_properties

bind sledi_top sledi_properties #(.SEC_CYC(SEC_CYC)) u_props (.i_clock, .i_rst_n,
  .i_usb_connected, .i_usb_suspended, .i_stop_error, .i_awaiting_cmd, .i_motor_on,
  .i_fb_mode, .i_target, .i_scaled_fb, .i_duty, .i_duty_target, .i_rd, .o_rdata,
  .o_led_green, .o_led_yellow, .o_led_red, .o_err, .o_startup_hold);

/* File: tb/tb_sledi_top.sv */
// Purpose: self-checking bench for the indicator block
// Assumes: one second shortened to SEC cycles
// Notes:   blink checks count highs and rises over one second
`timescale 1ns/1ps
module tb_sledi_top;
  localparam int SEC = 1600;
  localparam int PUL = 20;
  localparam int FLK = 20;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_usb_connected = 1'b0, i_usb_recognized = 1'b0;
  logic i_usb_activity = 1'b0, i_usb_suspended = 1'b0, i_stop_error = 1'b0;
  logic i_awaiting_cmd = 1'b0, i_motor_on = 1'b0, i_special_reset = 1'b0, i_wr = 1'b0;
  logic i_rd = 1'b0, clr = 1'b0, peer = 1'b0, shared;
  logic [1:0]  i_fb_mode = 2'h1;
  logic [15:0] i_target = 16'h0, i_scaled_fb = 16'h64;
  logic [10:0] i_duty = 11'h0, i_duty_target = 11'h0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic o_led_green, o_led_yellow, o_led_red, o_err, o_startup_hold, o_irq;
  int failures = 0, compares = 0, y_hi, y_rise, g_hi, g_rise;
  int yh_e = 0, yr_e = 0, gh_e = 0, gr_e = 0;

  always #5 i_clock = ~i_clock;

  sledi_top #(.SEC_CYC(SEC), .PULSE_CYC(PUL), .FLICK_CYC(FLK)) dut (.i_clock, .i_rst_n,
    .i_usb_connected, .i_usb_recognized, .i_usb_activity, .i_usb_suspended, .i_stop_error,
    .i_awaiting_cmd, .i_motor_on, .i_fb_mode, .i_target, .i_scaled_fb, .i_duty,
    .i_duty_target, .i_special_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_led_green, .o_led_yellow, .o_led_red, .o_err, .o_startup_hold, .o_irq);
  sledi_led_mon u_mon (.i_clock, .i_clear(clr), .i_green(o_led_green),
    .i_yellow(o_led_yellow), .i_err(o_err), .i_peer_err(peer), .o_shared_err(shared),
    .o_y_hi(y_hi), .o_y_rise(y_rise), .o_g_hi(g_hi), .o_g_rise(g_rise));

  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic rst(input logic special);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    i_special_reset <= special;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
  endtask : rst

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd

  // one second window; any window of one period holds exactly one rise
  task automatic meas(input logic act);
    @(posedge i_clock);
    clr <= 1'b1;
    @(posedge i_clock);
    clr <= 1'b0;
    for (int i = 0; i < SEC; i++) begin
      @(posedge i_clock);
      i_usb_activity <= act && i == 100;
    end
    #1 chk(y_hi, yh_e);
    chk(y_rise, yr_e);
    chk(g_hi, gh_e);
    chk(g_rise, gr_e);
  endtask : meas

  task automatic gc(input logic c, r, s, a, input int gh, gr);
    @(posedge i_clock);
    i_usb_connected <= c;
    i_usb_recognized <= r;
    i_usb_suspended <= s;
    gh_e = gh;
    gr_e = gr;
    repeat (3) @(posedge i_clock);
    meas(a);
  endtask : gc

  task automatic yc(input logic [1:0] m, input logic [15:0] t, f, input logic [10:0] d, dt,
                    input logic mo, aw, er, input int yh, yr);
    @(posedge i_clock);
    i_fb_mode <= m;
    i_target <= t;
    i_scaled_fb <= f;
    i_duty <= d;
    i_duty_target <= dt;
    i_motor_on <= mo;
    i_awaiting_cmd <= aw;
    i_stop_error <= er;
    yh_e = yh;
    yr_e = yr;
    repeat (3) @(posedge i_clock);
    meas(1'b0);
    chk(o_led_red, er);
    chk(o_err, er);
  endtask : yc

  initial begin
    repeat (40000) @(posedge i_clock);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst(1'b0);
    repeat (3) @(posedge i_clock);
    #1 chk(o_startup_hold, 1'b0);
    rd(sledi_pkg::REG_IRQ_MK, 32'h0);
    wr(sledi_pkg::REG_IRQ_ST, 32'hf);
    wr(sledi_pkg::REG_IRQ_MK, 32'h1);
    i_stop_error <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1 chk(o_irq, 1'b1);
    rd(sledi_pkg::REG_STATUS, 32'h9);
    rd(sledi_pkg::REG_IRQ_ST, 32'h1);
    wr(sledi_pkg::REG_IRQ_ST, 32'h1);
    rd(sledi_pkg::REG_IRQ_ST, 32'h0);
    chk(o_irq, 1'b0);
    wr(sledi_pkg::REG_IRQ_MK, 32'h2);
    i_stop_error <= 1'b0;
    peer <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1 chk(shared, 1'b1);
    chk(o_err, 1'b0);
    chk(o_irq, 1'b1);
    rd(sledi_pkg::REG_IRQ_ST, 32'h2);
    wr(4'hc, 32'hff);
    rd(4'hc, 32'h0);
    rd(sledi_pkg::REG_IRQ_MK, 32'h2);
    peer <= 1'b0;
    gc(1'b1, 1'b0, 1'b0, 1'b0, SEC / 2, 1);
    gc(1'b1, 1'b1, 1'b1, 1'b0, PUL, 1);
    gc(1'b1, 1'b1, 1'b0, 1'b0, SEC, 0);
    gc(1'b1, 1'b1, 1'b0, 1'b1, SEC - FLK, 1);
    gh_e = SEC;
    gr_e = 0;
    yc(2'h1, 16'h3e8, 16'h3fc, 11'h0, 11'h0, 1'b1, 1'b0, 1'b0, SEC, 0);
    yc(2'h1, 16'h3e8, 16'h3fd, 11'h0, 11'h0, 1'b1, 1'b0, 1'b0, SEC / 2, 16);
    yc(2'h2, 16'h3e8, 16'h3d4, 11'h0, 11'h0, 1'b1, 1'b0, 1'b0, SEC, 0);
    yc(2'h2, 16'h3e8, 16'h3d3, 11'h0, 11'h0, 1'b1, 1'b0, 1'b0, SEC / 2, 16);
    yc(2'h0, 16'h0, 16'h0, 11'h5, 11'h5, 1'b1, 1'b0, 1'b0, SEC, 0);
    yc(2'h0, 16'h0, 16'h0, 11'h5, 11'h6, 1'b1, 1'b0, 1'b0, SEC / 2, 16);
    yc(2'h0, 16'h0, 16'h0, 11'h0, 11'h0, 1'b1, 1'b0, 1'b0, SEC / 2, 1);
    yc(2'h1, 16'h3e8, 16'h3e8, 11'h0, 11'h0, 1'b1, 1'b1, 1'b0, SEC / 2, 1);
    yc(2'h1, 16'h3e8, 16'h3e8, 11'h0, 11'h0, 1'b1, 1'b1, 1'b1, 0, 0);
    yc(2'h1, 16'h3e8, 16'h3e8, 11'h0, 11'h0, 1'b0, 1'b0, 1'b0, 0, 0);
    rd(sledi_pkg::REG_IRQ_ST, 32'hf);
    @(posedge i_clock);
    i_usb_connected <= 1'b0;
    i_usb_recognized <= 1'b0;
    gh_e = 0;
    yh_e = SEC / 2;
    yr_e = 8;
    rst(1'b1);
    fork
      meas(1'b0);
      begin
        repeat (800) @(posedge i_clock);
        #1 chk(o_led_red, 1'b1);
        chk(o_startup_hold, 1'b1);
      end
    join
    repeat (20) @(posedge i_clock);
    #1 chk(o_startup_hold, 1'b0);
    chk(o_led_red, 1'b0);
    tally_and_finish();
  end
endmodule : tb_sledi_top
